// *** verilog/pdt_pkg.sv ***
/*
 * Shared definitions of the periodic down timer: register map, field
 * positions, reset values, timing counts and the register bus carrier.
 * Assumes a single 250 MHz clock domain and a synchronous active-high reset.
 */
package pdt_pkg;

  // ****************************************************************
  // Register bus
  // ****************************************************************
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 16;

  // Request from the register bus master, one cycle per access
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } pdt_bus_req_t;

  // ****************************************************************
  // Register offsets (byte addresses, one word each)
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFS_CONFIG  = 8'h00; // periodic_config_register
  localparam logic [ADDR_W-1:0] OFS_PRELOAD = 8'h04; // countdown_preload
  localparam logic [ADDR_W-1:0] OFS_COUNT   = 8'h08; // live_count_value, read only
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h0c; // interrupt_status_register
  localparam logic [ADDR_W-1:0] OFS_CLEAR   = 8'h10; // write-one-to-clear, write only
  localparam logic [ADDR_W-1:0] OFS_ENABLE  = 8'h14; // wrap_irq_enable

  // ****************************************************************
  // Field positions and reset values
  // ****************************************************************
  localparam int BIT_RUN_EN   = 0; // run enable in config
  localparam int BIT_WRAP     = 0; // wrap_event_flag in status, clear and enable
  localparam logic [CNT_W-1:0] PRELOAD_RST = 16'hffff;
  localparam logic [CNT_W-1:0] COUNT_RST   = 16'hffff;
  localparam logic [CNT_W-1:0] COUNT_WRAP  = 16'hffff;
  localparam logic [CNT_W-1:0] COUNT_ZERO  = 16'h0000;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int TICK_TIME_US  = 100;
  localparam int TICK_CYCLES   = (TICK_TIME_US * 1000) / CLK_PERIOD_NS;

endpackage

// *** verilog/pdt_prescaler.sv ***
/*
 * Prescaler of the periodic down timer: one-cycle tick every TICK_CYCLES
 * clocks while running. Assumes run and restart come from the same clock.
 */
`timescale 1ns/1ps
module pdt_prescaler import pdt_pkg::*; #(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Control
  input  wire logic run,
  input  wire logic restart,
  // Tick out
  output logic      tick
);

  localparam int PW = $clog2(TICK_CYCLES_P + 1);
  localparam logic [PW-1:0] LAST = PW'(TICK_CYCLES_P - 1);

  typedef struct packed {
    logic [PW-1:0] cnt;
    logic          tick;
  } pdt_pre_state_t;

  pdt_pre_state_t st_reg;
  pdt_pre_state_t st_next;

  // Count clocks, restart from zero on request or while stopped
  always_comb begin
    st_next      = st_reg;
    st_next.tick = 1'b0;
    if (!run || restart) begin
      st_next.cnt = '0;
    end else if (st_reg.cnt == LAST) begin
      st_next.cnt  = '0;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + PW'(1);
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign tick = st_reg.tick;

endmodule // pdt_prescaler

// *** verilog/pdt_timer.sv ***
/*
 * Periodic down timer: a 16-bit counter stepping down once per 100 us,
 * wrapping from zero to all ones with a sticky wrap flag, set only while
 * wrap_irq_enable is set, and a level interrupt, reached over a plain register port.
 * Assumes the bus master keeps strobes one cycle long and never both at
 * once, and that all inputs come from logic on the same clock.
 */
// The placing of the registers and the strobed register port were decided locally.
`timescale 1ns/1ps
module pdt_timer import pdt_pkg::*; #(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // Register port
  input  wire pdt_bus_req_t      bus_req,
  output logic [DATA_W-1:0]      rd_data,
  // Interrupt
  output logic                   irq
);

  // ****************************************************************
  // State
  // ****************************************************************

  typedef struct packed {
    logic              run_en;    // Run enable bit
    logic              irq_en;    // wrap_irq_enable
    logic [CNT_W-1:0]  preload;   // countdown_preload
    logic [CNT_W-1:0]  count;     // live_count_value
    logic              wrap_flag; // wrap_event_flag
    logic [DATA_W-1:0] rdata;     // Read data, valid one cycle after strobe
  } pdt_state_t;

  pdt_state_t st_reg;
  pdt_state_t st_next;

  logic tick;
  logic restart;

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Write strobe aimed at one register
  function automatic logic wr_hit(input pdt_bus_req_t req,
                                  input logic [ADDR_W-1:0] ofs);
    wr_hit = req.wr && (req.addr == ofs);
  endfunction

  // Read strobe aimed at one register
  function automatic logic rd_hit(input pdt_bus_req_t req,
                                  input logic [ADDR_W-1:0] ofs);
    rd_hit = req.rd && (req.addr == ofs);
  endfunction

  // Place a narrow value in the low bits of a read word
  function automatic logic [DATA_W-1:0] low16(input logic [CNT_W-1:0] v);
    low16 = {{(DATA_W-CNT_W){1'b0}}, v};
  endfunction

  // Place a single bit at a field position of a read word
  function automatic logic [DATA_W-1:0] bit_at(input logic b, input int pos);
    logic [DATA_W-1:0] w;
    w      = '0;
    w[pos] = b;
    bit_at = w;
  endfunction

  // ****************************************************************
  // Control decode
  // ****************************************************************

  logic cfg_wr;
  logic pre_wr;
  logic run_wdata;
  logic run_rise;
  logic run_fall;
  logic wrap_clr;
  logic wrap_evt;

  // Run enable edges seen at the config write
  assign cfg_wr    = wr_hit(bus_req, OFS_CONFIG);
  assign pre_wr    = wr_hit(bus_req, OFS_PRELOAD);
  assign run_wdata = bus_req.wdata[BIT_RUN_EN];
  assign run_rise  = cfg_wr && run_wdata && !st_reg.run_en;
  assign run_fall  = cfg_wr && !run_wdata && st_reg.run_en;

  // Clear by a one in the clear register or in the status register
  assign wrap_clr = (wr_hit(bus_req, OFS_CLEAR) || wr_hit(bus_req, OFS_STATUS))
                    && bus_req.wdata[BIT_WRAP];

  // Wrap happens on a tick while running with the count at zero
  assign wrap_evt = st_reg.run_en && tick && (st_reg.count == COUNT_ZERO);

  // Prescaler starts over on enable and on a preload while running
  assign restart = run_rise || (pre_wr && st_reg.run_en);

  // ****************************************************************
  // Prescaler
  // ****************************************************************

  // 100 us tick from the 250 MHz clock
  pdt_prescaler #(
    .TICK_CYCLES_P (TICK_CYCLES_P)
  ) u_prescaler (
    .clk     (clk),
    .rst     (rst),
    .run     (st_reg.run_en),
    .restart (restart),
    .tick    (tick)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************

  // Registers, counter, flag and read data
  always_comb begin
    st_next       = st_reg;
    st_next.rdata = '0;

    // Config: run enable
    if (cfg_wr) begin
      st_next.run_en = run_wdata;
    end

    // Interrupt enable register
    if (wr_hit(bus_req, OFS_ENABLE)) begin
      st_next.irq_en = bus_req.wdata[BIT_WRAP];
    end

    // Preload: any time, and back to all ones on disable
    if (pre_wr) begin
      st_next.preload = bus_req.wdata[CNT_W-1:0];
    end else if (run_fall) begin
      st_next.preload = PRELOAD_RST;
    end

    // Counter
    if (run_rise) begin
      st_next.count = st_reg.preload;
    end else if (pre_wr && st_reg.run_en) begin
      st_next.count = bus_req.wdata[CNT_W-1:0];
    end else if (st_reg.run_en && tick) begin
      if (st_reg.count == COUNT_ZERO) begin
        st_next.count = COUNT_WRAP;
      end else begin
        st_next.count = st_reg.count - CNT_W'(1);
      end
    end

    // Sticky flag; a wrap in the clearing cycle wins
    if (wrap_evt && st_reg.irq_en) begin
      st_next.wrap_flag = 1'b1;
    end else if (wrap_clr) begin
      st_next.wrap_flag = 1'b0;
    end

    // Read mux; write-only and unmapped offsets read zero
    if (rd_hit(bus_req, OFS_CONFIG)) begin
      st_next.rdata = bit_at(st_reg.run_en, BIT_RUN_EN);
    end else if (rd_hit(bus_req, OFS_PRELOAD)) begin
      st_next.rdata = low16(st_reg.preload);
    end else if (rd_hit(bus_req, OFS_COUNT)) begin
      st_next.rdata = low16(st_reg.count);
    end else if (rd_hit(bus_req, OFS_STATUS)) begin
      st_next.rdata = bit_at(st_reg.wrap_flag, BIT_WRAP);
    end else if (rd_hit(bus_req, OFS_ENABLE)) begin
      st_next.rdata = bit_at(st_reg.irq_en, BIT_WRAP);
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************

  // Reset values of all state
  always_ff @(posedge clk) begin
    if (rst) begin
      st_reg.run_en    <= 1'b0;
      st_reg.irq_en    <= 1'b0;
      st_reg.preload   <= PRELOAD_RST;
      st_reg.count     <= COUNT_RST;
      st_reg.wrap_flag <= 1'b0;
      st_reg.rdata     <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // Read data and level interrupt
  assign rd_data = st_reg.rdata;
  assign irq     = st_reg.wrap_flag && st_reg.irq_en;

endmodule // pdt_timer

// *** verif/pdt_timer_properties.sv ***
/*
 * Checker of the periodic down timer, bound to its top module.
 * Assumes one clock, synchronous active-high reset, one-cycle strobes.
 */
`timescale 1ns/1ps
module pdt_timer_chk import pdt_pkg::*; #(
  parameter int TICK_CYCLES_P = TICK_CYCLES
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst,
  // Register port
  input wire pdt_bus_req_t      bus_req,
  input wire logic [DATA_W-1:0] rd_data,
  // Interrupt
  input wire logic              irq
);
  // ****************************************************************
  // Decoded accesses
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire logic w_cfg = bus_req.wr && bus_req.addr == OFS_CONFIG;
  wire logic w_pre = bus_req.wr && bus_req.addr == OFS_PRELOAD;
  wire logic w_en  = bus_req.wr && bus_req.addr == OFS_ENABLE;
  wire logic r_pre = bus_req.rd && bus_req.addr == OFS_PRELOAD;
  wire logic r_cnt = bus_req.rd && bus_req.addr == OFS_COUNT;
  wire logic r_sts = bus_req.rd && bus_req.addr == OFS_STATUS;
  wire logic w_clr = bus_req.wr && bus_req.wdata[BIT_WRAP] &&
                     (bus_req.addr == OFS_CLEAR || bus_req.addr == OFS_STATUS);
  wire logic run1  = bus_req.wdata[BIT_RUN_EN];

  chk_preload_store: assert property (w_pre ##1 r_pre |=>
    rd_data == {16'h0000, $past(bus_req.wdata[15:0], 2)}) else $error("preload readback wrong");
  chk_enable_load: assert property (w_pre ##1 (w_cfg && run1) ##1 r_cnt |=>
    rd_data[15:0] == $past(bus_req.wdata[15:0], 3)) else $error("count not loaded on enable");
  chk_disable_preload: assert property ((w_cfg && run1) ##1 (w_cfg && !run1) ##1 r_pre |=>
    rd_data[15:0] == PRELOAD_RST) else $error("preload not reset on disable");
  chk_stopped_hold: assert property ((w_cfg && !run1) ##1 r_cnt ##1 r_cnt |=>
    rd_data == $past(rd_data)) else $error("stopped count moved");
  chk_irq_gate: assert property ((w_en && !bus_req.wdata[BIT_WRAP]) |=> !irq)
    else $error("irq high while disabled");
  chk_irq_mirror: assert property ((w_en && bus_req.wdata[BIT_WRAP]) ##1 r_sts |=>
    rd_data[BIT_WRAP] == $past(irq)) else $error("irq differs from flag");
  chk_flag_sticky: assert property (irq && !w_clr && !w_en |=> irq)
    else $error("flag dropped without clear");
  chk_flag_clear: assert property (w_clr ##1 w_clr |=> !$past(irq) || !irq)
    else $error("flag not cleared");
endmodule // pdt_timer_chk

bind pdt_timer pdt_timer_chk #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_chk (
  .clk(clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data), .irq(irq));

// *** verif/tb_periodic_down_timer.sv ***
/*
 * Self-checking bench of the periodic down timer over its register port.
 * Assumes the checker is bound in and a short tick of T clocks.
 */
`timescale 1ns/1ps
module tb_periodic_down_timer import pdt_pkg::*;;
  // ****************************************************************
  // Stimulus and checks
  // ****************************************************************
  localparam int T = 4;
  logic              clk       = 1'b0;
  logic              rst       = 1'b1;
  pdt_bus_req_t      bus_req   = '0;
  logic [DATA_W-1:0] rd_data;
  logic              irq;
  int                n_errors  = 0;
  int                tests_run = 0;
  int                n;

  // Clock of 4 ns
  always #2 clk = ~clk;

  pdt_timer #(.TICK_CYCLES_P(T)) DUT (.clk(clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data), .irq(irq));

  // Compare and count
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      $display("unexpected %s: expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask
  // One bus cycle, driven just after an edge
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: w, rd: r};
  endtask
  // Idle cycle, then let the edge's updates land
  task automatic settle;
    bus(1'b0, 1'b0, 8'h00, 32'h0);
    #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
    bus(1'b0, 1'b1, a, 32'h0);
    settle();
    chk(nm, e, rd_data);
  endtask
  // Edges until irq rises, bounded
  task automatic wait_irq(output int c);
    c = 0;
    while (irq !== 1'b1 && c < 100) begin
      @(posedge clk);
      #1 c++;
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #20000;
    n_errors++;
    test_done();
  end

  // Test sequence
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    rd_chk(OFS_PRELOAD, 32'h0000ffff, "preload");
    rd_chk(OFS_COUNT, 32'h0000ffff, "count");
    rd_chk(OFS_STATUS, 32'h0, "status");
    chk("irq", 32'h0, irq);
    $display("reset test done");
    bus(1'b1, 1'b0, 8'h20, 32'hffffffff);
    rd_chk(8'h20, 32'h0, "unmapped");
    rd_chk(OFS_CLEAR, 32'h0, "clear");
    $display("unmapped test done");
    bus(1'b1, 1'b0, OFS_PRELOAD, 32'h5);
    rd_chk(OFS_PRELOAD, 32'h5, "preload");
    repeat (3 * T) @(posedge clk);
    rd_chk(OFS_COUNT, 32'h0000ffff, "count");
    $display("stopped test done");
    bus(1'b1, 1'b0, OFS_ENABLE, 32'h1);
    bus(1'b0, 1'b1, OFS_STATUS, 32'h0);
    bus(1'b1, 1'b0, OFS_PRELOAD, 32'h1);
    bus(1'b1, 1'b0, OFS_CONFIG, 32'h1);
    rd_chk(OFS_COUNT, 32'h1, "count");
    wait_irq(n);
    chk("wrap delay", 2 * T, n);
    rd_chk(OFS_COUNT, 32'h0000ffff, "count");
    rd_chk(OFS_STATUS, 32'h1, "status");
    $display("wrap test done");
    bus(1'b1, 1'b0, OFS_STATUS, 32'h0);
    settle();
    chk("irq", 32'h1, irq);
    bus(1'b1, 1'b0, OFS_CLEAR, 32'h1);
    bus(1'b1, 1'b0, OFS_CLEAR, 32'h1);
    settle();
    chk("irq", 32'h0, irq);
    $display("sticky test done");
    bus(1'b1, 1'b0, OFS_PRELOAD, 32'h3);
    rd_chk(OFS_COUNT, 32'h3, "count");
    wait_irq(n);
    chk("restart delay", 4 * T, n);
    bus(1'b1, 1'b0, OFS_ENABLE, 32'h0);
    settle();
    chk("irq", 32'h0, irq);
    rd_chk(OFS_STATUS, 32'h1, "status");
    bus(1'b1, 1'b0, OFS_CLEAR, 32'h1);
    bus(1'b1, 1'b0, OFS_PRELOAD, 32'h0);
    settle();
    repeat (2 * T) @(posedge clk);
    rd_chk(OFS_STATUS, 32'h0, "status");
    bus(1'b1, 1'b0, OFS_ENABLE, 32'h1);
    bus(1'b0, 1'b1, OFS_STATUS, 32'h0);
    $display("gating test done");
    bus(1'b1, 1'b0, OFS_CONFIG, 32'h1);
    bus(1'b1, 1'b0, OFS_CONFIG, 32'h0);
    rd_chk(OFS_PRELOAD, 32'h0000ffff, "preload");
    bus(1'b1, 1'b0, OFS_CONFIG, 32'h0);
    bus(1'b0, 1'b1, OFS_COUNT, 32'h0);
    bus(1'b0, 1'b1, OFS_COUNT, 32'h0);
    settle();
    $display("disable test done");
    test_done();
  end
endmodule // tb_periodic_down_timer
